//--- hdl/seq_cnt_if.sv
// Purpose: carrier between the queue and one of its event counters
// Assumes: single clock domain
// Notes:   ctl drives the counter, cnt is the counter itself
interface seq_cnt_if;
  logic       inc;
  logic       clr;
  logic [9:0] count;
  logic       ovf;
  modport ctl (output inc, output clr, input count, input ovf);
  modport cnt (input inc, input clr, output count, output ovf);
endinterface : seq_cnt_if

//--- hdl/seq_counter.sv
// Purpose: ten-bit event counter, cleared by a read
// Assumes: inc and clr are single-cycle strobes
// Notes:   ovf pulses in the same cycle that the count passes 1ffh
module seq_counter (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  seq_cnt_if.cnt    bus
);
  logic [9:0] next_count;

  // an increment in the clearing cycle survives as a count of one
  assign next_count = bus.clr ? {9'h000, bus.inc} : bus.count + {9'h000, bus.inc};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus.count <= seq_pkg::CNT_RESET;
      bus.ovf   <= 1'b0;
    end else if (ce) begin
      bus.count <= next_count;
      bus.ovf   <= bus.inc && !bus.clr && bus.count == seq_pkg::CNT_WRAP_POINT;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  count_read_clear_a: assert property (ce && bus.clr && !bus.inc |=> bus.count == 10'h000)
    else $error("counter not cleared by read");
  count_step_a: assert property (ce && !bus.clr && bus.inc && bus.count != 10'h3ff
                                 |=> bus.count == $past(bus.count) + 10'h001)
    else $error("counter did not step");
endmodule : seq_counter

//--- hdl/seq_pkg.sv
// Purpose: shared constants of the status event queue
// Assumes: 9-bit register offsets, 16-bit register words
// Notes:   low six bits of every status word carry its register code
package seq_pkg;
  // ==========================================================
  // register offsets
  localparam logic [8:0] OFF_QUEUE_HEAD  = 9'h120;
  localparam logic [8:0] OFF_IO_QUEUE    = 9'h008;
  localparam logic [8:0] OFF_RX_FLAGS    = 9'h124;
  localparam logic [8:0] OFF_TX_FLAGS    = 9'h128;
  localparam logic [8:0] OFF_BUF_FLAGS   = 9'h12c;
  localparam logic [8:0] OFF_MISS_COUNT  = 9'h130;
  localparam logic [8:0] OFF_COL_COUNT   = 9'h132;
  localparam logic [8:0] OFF_LINE_STATE  = 9'h134;
  localparam logic [8:0] OFF_SELF_STATE  = 9'h136;
  localparam logic [8:0] OFF_BUS_STATE   = 9'h138;
  localparam logic [8:0] OFF_REFL_COUNT  = 9'h13c;
  // ==========================================================
  // register codes in bits 5:0
  localparam logic [5:0] CODE_RX         = 6'h04;
  localparam logic [5:0] CODE_TX         = 6'h08;
  localparam logic [5:0] CODE_BUF        = 6'h0c;
  localparam logic [5:0] CODE_MISS       = 6'h10;
  localparam logic [5:0] CODE_COL        = 6'h12;
  localparam logic [5:0] CODE_LINE       = 6'h14;
  localparam logic [5:0] CODE_SELF       = 6'h16;
  localparam logic [5:0] CODE_BUS        = 6'h18;
  localparam logic [5:0] CODE_REFL       = 6'h1c;
  // ==========================================================
  // field layout and counts
  localparam int         PAYLOAD_W       = 10;
  localparam int         CODE_W          = 6;
  localparam int         NUM_SRC         = 5;
  localparam int         NUM_CNT         = 3;
  localparam int         SRC_RX          = 0;
  localparam int         SRC_TX          = 1;
  localparam int         SRC_BUF         = 2;
  localparam int         SRC_MISS        = 3;
  localparam int         SRC_COL         = 4;
  localparam int         CNT_MISS        = 0;
  localparam int         CNT_COL         = 1;
  localparam int         CNT_REFL        = 2;
  localparam int         RX_HASHED_BIT   = 3;
  localparam int         RX_GOOD_BIT     = 2;
  localparam int         HASH_W          = 6;
  localparam logic [9:0] CNT_WRAP_POINT  = 10'h1ff;
  localparam logic [9:0] CNT_RESET       = 10'h000;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  localparam logic [9:0] FLAGS_RESET     = 10'h000;
endpackage : seq_pkg

//--- hdl/seq_status_queue.sv
// Purpose: interrupt status queue with event, counter and state registers
// Assumes: event strobes and read strobes are synchronous to mclk
// Notes:   read data appears one cycle after rd_en
module seq_status_queue (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        rd_en,
  input  wire logic        rd_io,
  input  wire logic [8:0]  rd_addr,
  output logic      [15:0] rd_data,
  output logic             irq,
  input  wire logic [9:0]  rx_set,
  input  wire logic [5:0]  rx_hash_index,
  input  wire logic [9:0]  rx_ie,
  input  wire logic [9:0]  tx_set,
  input  wire logic [9:0]  tx_ie,
  input  wire logic [9:0]  buf_set,
  input  wire logic [9:0]  buf_ie,
  input  wire logic        miss_inc,
  input  wire logic        miss_ovf_ie,
  input  wire logic        col_inc,
  input  wire logic        col_ovf_ie,
  input  wire logic        refl_inc,
  input  wire logic [9:0]  line_state,
  input  wire logic [9:0]  self_state,
  input  wire logic [9:0]  bus_state
);
  // ==========================================================
  // read decode
  logic        hit_queue;
  logic        hit_rx;
  logic        hit_tx;
  logic        hit_buf;
  logic        hit_miss;
  logic        hit_col;
  logic        hit_refl;
  logic        rd_mem;

  assign rd_mem    = rd_en && !rd_io;
  assign hit_queue = rd_en && (rd_io ? rd_addr == seq_pkg::OFF_IO_QUEUE
                                     : rd_addr == seq_pkg::OFF_QUEUE_HEAD);
  assign hit_rx    = rd_mem && rd_addr == seq_pkg::OFF_RX_FLAGS;
  assign hit_tx    = rd_mem && rd_addr == seq_pkg::OFF_TX_FLAGS;
  assign hit_buf   = rd_mem && rd_addr == seq_pkg::OFF_BUF_FLAGS;
  assign hit_miss  = rd_mem && rd_addr == seq_pkg::OFF_MISS_COUNT;
  assign hit_col   = rd_mem && rd_addr == seq_pkg::OFF_COL_COUNT;
  assign hit_refl  = rd_mem && rd_addr == seq_pkg::OFF_REFL_COUNT;

  // ==========================================================
  // event registers
  logic [9:0]  rx_flags;
  logic [9:0]  tx_flags;
  logic [9:0]  buf_flags;
  logic [9:0]  rx_eff;
  logic [9:0]  next_rx;
  logic [9:0]  next_tx;
  logic [9:0]  next_buf;
  logic [4:0]  pending;
  logic [4:0]  next_pending;
  logic [4:0]  sel;
  logic [4:0]  clr_src;
  logic [4:0]  raise;

  // a hashed good frame carries its hash index in the upper field
  assign rx_eff = (rx_set[seq_pkg::RX_HASHED_BIT] && rx_set[seq_pkg::RX_GOOD_BIT])
                ? {rx_hash_index, rx_set[3:0]} : rx_set;

  // lowest pending source is served first
  assign sel     = pending & (~pending + 5'h01);
  assign clr_src = ({5{hit_queue}} & sel) | {hit_col, hit_miss, hit_buf, hit_tx, hit_rx};

  // flags latch whether or not enabled; a set in the clearing cycle wins
  assign next_rx  = (clr_src[seq_pkg::SRC_RX]  ? seq_pkg::FLAGS_RESET : rx_flags)  | rx_eff;
  assign next_tx  = (clr_src[seq_pkg::SRC_TX]  ? seq_pkg::FLAGS_RESET : tx_flags)  | tx_set;
  assign next_buf = (clr_src[seq_pkg::SRC_BUF] ? seq_pkg::FLAGS_RESET : buf_flags) | buf_set;

  // ==========================================================
  // counters
  seq_cnt_if cnt_bus[seq_pkg::NUM_CNT] ();
  logic [2:0]  cnt_inc;
  logic [2:0]  cnt_clr;
  logic [9:0]  cnt_val[seq_pkg::NUM_CNT];
  logic [2:0]  cnt_ovf;

  assign cnt_inc = {refl_inc, col_inc, miss_inc};
  assign cnt_clr = {hit_refl, clr_src[seq_pkg::SRC_COL], clr_src[seq_pkg::SRC_MISS]};

  genvar gi;
  generate
    for (gi = 0; gi < seq_pkg::NUM_CNT; gi++) begin : g_cnt
      assign cnt_bus[gi].inc = cnt_inc[gi];
      assign cnt_bus[gi].clr = cnt_clr[gi];
      assign cnt_val[gi]     = cnt_bus[gi].count;
      assign cnt_ovf[gi]     = cnt_bus[gi].ovf;
      seq_counter u_cnt (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .bus  (cnt_bus[gi])
      );
    end
  endgenerate

  // ==========================================================
  // queue
  assign raise = {cnt_ovf[seq_pkg::CNT_COL] & col_ovf_ie,
                  cnt_ovf[seq_pkg::CNT_MISS] & miss_ovf_ie,
                  |(buf_set & buf_ie),
                  |(tx_set & tx_ie),
                  |(rx_eff & rx_ie)};
  assign next_pending = (pending & ~clr_src) | raise;

  logic [15:0] word_rx;
  logic [15:0] word_tx;
  logic [15:0] word_buf;
  logic [15:0] word_miss;
  logic [15:0] word_col;
  logic [15:0] queue_word;
  logic [15:0] next_rd_data;

  assign word_rx   = {rx_flags, seq_pkg::CODE_RX};
  assign word_tx   = {tx_flags, seq_pkg::CODE_TX};
  assign word_buf  = {buf_flags, seq_pkg::CODE_BUF};
  assign word_miss = {cnt_val[seq_pkg::CNT_MISS], seq_pkg::CODE_MISS};
  assign word_col  = {cnt_val[seq_pkg::CNT_COL], seq_pkg::CODE_COL};
  // empty queue reads as all zeros
  assign queue_word = ({16{sel[seq_pkg::SRC_RX]}}   & word_rx)
                    | ({16{sel[seq_pkg::SRC_TX]}}   & word_tx)
                    | ({16{sel[seq_pkg::SRC_BUF]}}  & word_buf)
                    | ({16{sel[seq_pkg::SRC_MISS]}} & word_miss)
                    | ({16{sel[seq_pkg::SRC_COL]}}  & word_col);

  assign next_rd_data =
      hit_queue ? queue_word :
      hit_rx    ? word_rx :
      hit_tx    ? word_tx :
      hit_buf   ? word_buf :
      hit_miss  ? word_miss :
      hit_col   ? word_col :
      !rd_mem   ? seq_pkg::WORD_RESET :
      rd_addr == seq_pkg::OFF_LINE_STATE ? {line_state, seq_pkg::CODE_LINE} :
      rd_addr == seq_pkg::OFF_SELF_STATE ? {self_state, seq_pkg::CODE_SELF} :
      rd_addr == seq_pkg::OFF_BUS_STATE  ? {bus_state, seq_pkg::CODE_BUS} :
      hit_refl  ? {cnt_val[seq_pkg::CNT_REFL], seq_pkg::CODE_REFL} :
      seq_pkg::WORD_RESET;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_flags  <= seq_pkg::FLAGS_RESET;
      tx_flags  <= seq_pkg::FLAGS_RESET;
      buf_flags <= seq_pkg::FLAGS_RESET;
      pending   <= 5'h00;
      rd_data   <= seq_pkg::WORD_RESET;
      irq       <= 1'b0;
    end else if (ce) begin
      rx_flags  <= next_rx;
      tx_flags  <= next_tx;
      buf_flags <= next_buf;
      pending   <= next_pending;
      rd_data   <= next_rd_data;
      irq       <= |next_pending;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence queue_read_s;
    ce && hit_queue && pending != 5'h00;
  endsequence

  irq_on_event_a: assert property (ce && |raise |=> irq)
    else $error("interrupt not raised on enabled event");
  flag_no_enable_a: assert property (ce && rx_set != 10'h000 && !hit_rx && !hit_queue
                                     |=> (rx_flags & $past(rx_eff)) == $past(rx_eff))
    else $error("event flag lost without enable");
  tx_read_clear_a: assert property (ce && hit_tx && tx_set == 10'h000 |=> tx_flags == 10'h000)
    else $error("transmit flags not cleared by read");
  queue_code_a: assert property (queue_read_s |=> rd_data[5:0] inside {6'h04, 6'h08, 6'h0c,
                                 6'h10, 6'h12})
    else $error("queue code outside the five sources");
  queue_payload_a: assert property (queue_read_s and ce && pending[0]
                                    |=> rd_data == {$past(rx_flags), 6'h04})
    else $error("queue payload mismatch");
  queue_empty_a: assert property (ce && hit_queue && pending == 5'h00 |=> rd_data == 16'h0000)
    else $error("empty queue not read as zero");
  queue_consume_a: assert property (queue_read_s and raise == 5'h00
                                    |=> pending == ($past(pending) & ~$past(sel)))
    else $error("queue entry not consumed");
  io_queue_a: assert property (ce && rd_en && rd_io && rd_addr == 9'h008 && pending != 5'h00
                               |=> rd_data != 16'h0000)
    else $error("queue not readable in i/o space");
  hash_index_a: assert property (ce && rx_set[3] && rx_set[2] && !hit_rx && !hit_queue
                                 |=> rx_flags[9:4] == ($past(rx_flags[9:4]) | $past(rx_hash_index)))
    else $error("hash index not stored");
endmodule : seq_status_queue

//--- test/seq_host_model.sv
// Purpose: host side of the register read port of the status event queue
// Assumes: reads launched at the falling edge, one strobe cycle per read
// Notes:   address lines hold the inverted address of the last read between reads, zero before the first
module seq_host_model (
  input  wire logic        mclk,
  output logic             rd_en,
  output logic             rd_io,
  output logic      [8:0]  rd_addr,
  input  wire logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rd_en   = 1'b0;
    rd_io   = 1'b0;
    rd_addr = 9'h000;
  end

  // ==========================================================
  // one read: strobe for one edge, answer taken one cycle later
  task automatic do_read(input logic io, input logic [8:0] addr, output logic [15:0] data);
    @(negedge mclk);
    rd_en   = 1'b1;
    rd_io   = io;
    rd_addr = addr;
    @(negedge mclk);
    rd_en   = 1'b0;
    data    = rd_data;
    rd_addr = ~addr;
  endtask : do_read
endmodule : seq_host_model

//--- test/tb_seq_status_queue.sv
// Purpose: self-checking bench of the status event queue
// Assumes: inputs change at the falling edge of mclk
// Notes:   miss and collision counters are run to overflow in full, 512 strobes over 1024 cycles
module tb_seq_status_queue;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, rst, ce, rd_en, rd_io, irq, miss_inc, col_inc, refl_inc;
  logic miss_ovf_ie, col_ovf_ie;
  logic [8:0]  rd_addr;
  logic [15:0] rd_data, got;
  logic [5:0]  rx_hash_index;
  logic [9:0]  rx_set, rx_ie, tx_set, tx_ie, buf_set, buf_ie, line_state, self_state, bus_state;
  int          bad_count, checks;

  seq_host_model host_u (.mclk(mclk), .rd_en(rd_en), .rd_io(rd_io), .rd_addr(rd_addr),
    .rd_data(rd_data));
  seq_status_queue dut_u (.mclk(mclk), .rst(rst), .ce(ce), .rd_en(rd_en), .rd_io(rd_io),
    .rd_addr(rd_addr), .rd_data(rd_data), .irq(irq), .rx_set(rx_set),
    .rx_hash_index(rx_hash_index), .rx_ie(rx_ie), .tx_set(tx_set), .tx_ie(tx_ie),
    .buf_set(buf_set), .buf_ie(buf_ie), .miss_inc(miss_inc), .miss_ovf_ie(miss_ovf_ie),
    .col_inc(col_inc), .col_ovf_ie(col_ovf_ie), .refl_inc(refl_inc),
    .line_state(line_state), .self_state(self_state), .bus_state(bus_state));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ==========================================================
  // comparison, read and event tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic io, input logic [8:0] addr, input logic [15:0] exp);
    host_u.do_read(io, addr, got);
    check(got, exp);
  endtask : rd

  task automatic ev(input logic [9:0] r, input logic [9:0] t, input logic [9:0] b);
    @(negedge mclk);
    rx_set  = r;
    tx_set  = t;
    buf_set = b;
    @(negedge mclk);
    rx_set  = 10'h000;
    tx_set  = 10'h000;
    buf_set = 10'h000;
  endtask : ev

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    bad_count = 0; checks = 0; rst = 1'b1; ce = 1'b1;
    rx_set = 10'h000; tx_set = 10'h000; buf_set = 10'h000; rx_hash_index = 6'h00;
    rx_ie = 10'h000; tx_ie = 10'h000; buf_ie = 10'h000;
    miss_inc = 1'b0; col_inc = 1'b0; refl_inc = 1'b0; miss_ovf_ie = 1'b0; col_ovf_ie = 1'b0;
    line_state = 10'h155; self_state = 10'h2aa; bus_state = 10'h0f0;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    rd(1'b0, 9'h120, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    // disabled event still latches but queues nothing
    ev(10'h020, 10'h000, 10'h000);
    check({15'h0000, irq}, 16'h0000);
    rd(1'b0, 9'h120, 16'h0000);
    rd(1'b0, 9'h124, {10'h020, 6'h04});
    rd(1'b0, 9'h124, 16'h0004);
    // three sources at once come out in priority order
    rx_ie = 10'h001; tx_ie = 10'h002; buf_ie = 10'h010;
    ev(10'h001, 10'h002, 10'h010);
    check({15'h0000, irq}, 16'h0001);
    rd(1'b0, 9'h120, {10'h001, 6'h04});
    rd(1'b0, 9'h120, {10'h002, 6'h08});
    rd(1'b0, 9'h120, {10'h010, 6'h0c});
    rd(1'b0, 9'h120, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    // queue through I/O space; other I/O offsets read zero
    ev(10'h000, 10'h002, 10'h000);
    rd(1'b1, 9'h120, 16'h0000);
    rd(1'b1, 9'h008, {10'h002, 6'h08});
    rd(1'b0, 9'h120, 16'h0000);
    // hashed good frame: upper field holds the hash index
    rx_ie = 10'h000; rx_hash_index = 6'h2a;
    ev(10'h00c, 10'h000, 10'h000);
    rd(1'b0, 9'h124, {6'h2a, 4'hc, 6'h04});
    // direct reads of the transmit and buffer flags clear them
    ev(10'h000, 10'h004, 10'h020);
    rd(1'b0, 9'h128, {10'h004, 6'h08});
    rd(1'b0, 9'h128, 16'h0008);
    rd(1'b0, 9'h12c, {10'h020, 6'h0c});
    rd(1'b0, 9'h12c, 16'h000c);
    // frozen by the clock enable: an enabled event is not taken
    ce = 1'b0;
    ev(10'h000, 10'h002, 10'h000);
    ce = 1'b1;
    check({15'h0000, irq}, 16'h0000);
    rd(1'b0, 9'h120, 16'h0000);
    // reset in mid-run drops a pending entry and its flags
    ev(10'h000, 10'h002, 10'h000);
    check({15'h0000, irq}, 16'h0001);
    @(negedge mclk);
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    check({15'h0000, irq}, 16'h0000);
    rd(1'b0, 9'h120, 16'h0000);
    rd(1'b0, 9'h128, 16'h0008);
    // state registers and an unmapped offset
    rd(1'b0, 9'h134, {10'h155, 6'h14});
    rd(1'b0, 9'h136, {10'h2aa, 6'h16});
    rd(1'b0, 9'h138, {10'h0f0, 6'h18});
    rd(1'b0, 9'h122, 16'h0000);
    // counters: clear on read, overflow report past 1ffh
    miss_ovf_ie = 1'b1; col_ovf_ie = 1'b1;
    for (int i = 0; i < 512; i++) begin
      @(negedge mclk);
      miss_inc = 1'b1; col_inc = 1'b1; refl_inc = (i < 5);
      @(negedge mclk);
      miss_inc = 1'b0; col_inc = 1'b0; refl_inc = 1'b0;
    end
    repeat (3) @(negedge mclk);
    check({15'h0000, irq}, 16'h0001);
    rd(1'b0, 9'h13c, {10'h005, 6'h1c});
    rd(1'b0, 9'h13c, 16'h001c);
    rd(1'b0, 9'h120, {10'h200, 6'h10});
    rd(1'b0, 9'h120, {10'h200, 6'h12});
    rd(1'b0, 9'h120, 16'h0000);
    rd(1'b0, 9'h130, 16'h0010);
    rd(1'b0, 9'h132, 16'h0012);
    check({15'h0000, irq}, 16'h0000);
    give_verdict();
  end
endmodule : tb_seq_status_queue
